// ===== design/peb_pkg.sv
package peb_pkg;

    // bus sequencer states
    typedef enum logic [1:0]
    {
        PEB_IDLE,
        PEB_PROG,
        PEB_DATA
    } peb_bus_e;

    // cycle lengths in oscillator periods
    localparam logic [3:0] PROG_LEN = 4'h6;
    localparam logic [3:0] DATA_LEN = 4'hc;
    localparam logic [3:0] PH_FIRST = 4'h1;
    // address latch strobe high in these phases
    localparam logic [3:0] ALE_FIRST = 4'h2;
    localparam logic [3:0] ALE_LAST = 4'h3;
    // request sampling phase of a program cycle
    localparam logic [3:0] REQ_PH = 4'h2;
    // low address on port 0 in these phases
    localparam logic [3:0] ADDR_FIRST = 4'h3;
    localparam logic [3:0] ADDR_LAST = 4'h4;
    // port 0 released from this phase
    localparam logic [3:0] FLOAT_FIRST = 4'h5;
    // strobe start phases
    localparam logic [3:0] CRS_FIRST = 4'h5;
    localparam logic [3:0] RD_FIRST = 4'h7;
    localparam logic [3:0] WR_FIRST = 4'h6;
    // write data held into the next cycle up to this phase
    localparam logic [3:0] HOLD_LAST = 4'h2;
    // top of internal program memory
    localparam logic [15:0] INT_ROM_TOP = 16'h0fff;
    // reset and idle latch values
    localparam logic [7:0] LATCH_RST = 8'hff;
    localparam logic [7:0] P0_IDLE = 8'hff;

endpackage : peb_pkg

// ===== design/peb_port_bus.sv
// Functional notes
// [RQ1] plain port read returns output latch AND sampled pin level
// [RQ2] read-modify-write reads return the output latch only
// [RQ3] software writes one to make a pin an input, keeps it later
// [RQ4] pins sampled as address latch strobe falls; async inputs allowed
// [RQ5] ports 1-3 source high two periods only on latch zero-to-one
// [RQ6] port 0 open-drain as port, full three-state as bus
// [RQ7] port 3 pins give alternate function while latch holds one
// [RQ8] software sets both strobe pin latches before data moves
// [RQ9] external access: high address on port 2, low address/data on port 0
// [RQ10] code disable low: all fetches external; high: below 4096 internal
// [RQ11] execution time identical for internal and external code
// [RQ12] short pointer move leaves port 2 at its latch value
// [RQ13] wide pointer move drives port 2 only during the access
// [RQ14] address strobe every sixth period, code strobe on external fetches
// [RQ15] data move is twelve periods, one address and one data strobe
// [RQ16] fetches come in pairs; an unused byte is discarded
// [RQ17] long instructions keep refetching the next byte
// [RQ18] port 0 latch loaded with ones at end of each bus cycle
// [RQ19] port 2 address sources high two periods, then pullups hold
// [RQ20] program cycle six periods, address T3, code strobe from T5
// [RQ21] data read turns bus in T5-T6, read strobe T7-T12
// [RQ22] write data from T6 held to next T2, store strobe T6-T12
// [RQ23] external latch captures low address on strobe falling edge
// [RQ24] strobe timing from a phase counter restarted each cycle
`timescale 1ns/1ns
module peb_port_bus
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic internal_code_disable_n,
    input wire logic fetch_req,
    input wire logic [15:0] fetch_addr,
    output logic fetch_ack,
    output logic [7:0] fetch_data,
    output logic [15:0] rom_addr,
    input wire logic [7:0] rom_data,
    input wire logic xmove_req,
    input wire logic xmove_write,
    input wire logic xmove_wide,
    input wire logic [15:0] xmove_addr,
    input wire logic [7:0] xmove_wdata,
    output logic xmove_done,
    output logic [7:0] xmove_rdata,
    input wire logic pwr_en,
    input wire logic [1:0] pwr_sel,
    input wire logic [7:0] pwr_data,
    input wire logic [1:0] prd_sel,
    input wire logic prd_rmw,
    output logic [7:0] prd_data,
    input wire logic [5:0] alt_sel,
    input wire logic [5:0] alt_out,
    output logic ale,
    output logic code_read_strobe_n,
    input wire logic [7:0] p0_in,
    output logic [7:0] p0_out,
    output logic [7:0] p0_oe,
    input wire logic [7:0] p1_in,
    output logic [7:0] p1_out,
    output logic [7:0] p1_oe,
    input wire logic [7:0] p2_in,
    output logic [7:0] p2_out,
    output logic [7:0] p2_oe,
    input wire logic [7:0] p3_in,
    output logic [7:0] p3_out,
    output logic [7:0] p3_oe
);

    typedef struct packed
    {
        peb_pkg::peb_bus_e st;
        logic [3:0] ph;
        logic [3:0][7:0] lat;
        logic [3:0][7:0] snap;
        logic [2:0][7:0] prev;
        logic [2:0][7:0] rise2;
        logic used;
        logic ext;
        logic pair_odd;
        logic dm_write;
        logic dm_wide;
        logic [15:0] dm_addr;
        logic [7:0] dm_wdata;
        logic [15:0] cyc_addr;
        logic hold_wr;
        logic [7:0] hold_data;
        logic fetch_ack;
        logic [7:0] fetch_data;
        logic xmove_done;
        logic [7:0] xmove_rdata;
        logic [7:0] prd_data;
    } peb_state_s;

    logic [1:0] rst_sync_q;
    logic rst_n;
    peb_state_s st_q;
    peb_state_s st_d;
    logic is_prog;
    logic is_data;
    logic bus_cyc;
    logic cyc_last;
    logic rd_n;
    logic wr_n;
    logic p2_bus;
    logic [7:0] bus_hi;
    logic [7:0] bus_lo;
    logic [7:0] p2_val;
    logic [7:0] p3_val;
    logic [2:0][7:0] eff;
    logic [2:0][7:0] rise1;
    logic [2:0][7:0] boost;

    // reset released through two flops so release is clean against mclk
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // cycle decode from the phase counter
    assign is_prog = (st_q.st == peb_pkg::PEB_PROG);
    assign is_data = (st_q.st == peb_pkg::PEB_DATA);
    assign bus_cyc = is_data || (is_prog && st_q.ext);
    assign cyc_last = (st_q.st == peb_pkg::PEB_IDLE) || (is_prog && st_q.ph == peb_pkg::PROG_LEN) ||
                      (is_data && st_q.ph == peb_pkg::DATA_LEN); // [RQ24]

    // strobes; internal fetches still run the address strobe, so timing matches
    assign ale = !(st_q.st == peb_pkg::PEB_IDLE) && st_q.ph >= peb_pkg::ALE_FIRST &&
                 st_q.ph <= peb_pkg::ALE_LAST; // [RQ14] [RQ20]
    assign code_read_strobe_n = !(is_prog && st_q.ext && st_q.ph >= peb_pkg::CRS_FIRST); // [RQ14] [RQ20]
    assign rd_n = !(is_data && !st_q.dm_write && st_q.ph >= peb_pkg::RD_FIRST); // [RQ21]
    assign wr_n = !(is_data && st_q.dm_write && st_q.ph >= peb_pkg::WR_FIRST); // [RQ22]

    // bus address; a short pointer never touches port 2
    assign bus_hi = is_data ? st_q.dm_addr[15:8] : st_q.cyc_addr[15:8];
    assign bus_lo = is_data ? st_q.dm_addr[7:0] : st_q.cyc_addr[7:0];
    assign p2_bus = ((is_prog && st_q.ext) || (is_data && st_q.dm_wide)) &&
                    st_q.ph >= peb_pkg::ADDR_FIRST; // [RQ9] [RQ12] [RQ13]
    assign p2_val = p2_bus ? bus_hi : st_q.lat[2];

    // port 3: strobes always gate bits 7/6, which idle high
    assign p3_val = st_q.lat[3] & {rd_n, wr_n, (alt_out | ~alt_sel)}; // [RQ7]

    // quasi-bidirectional boost: two periods of strong high after a rise
    assign eff = {st_q.lat[3], p2_val, st_q.lat[1]};
    assign rise1 = eff & ~st_q.prev;
    assign boost = rise1 | st_q.rise2; // [RQ5] [RQ19]

    // ports 1-3 sink low, source high only while boosted
    assign p1_out = st_q.lat[1];
    assign p1_oe = ~st_q.lat[1] | boost[0]; // [RQ5]
    assign p2_out = p2_val;
    assign p2_oe = ~p2_val | boost[1]; // [RQ19]
    assign p3_out = p3_val;
    assign p3_oe = ~p3_val | (boost[2] & p3_val); // [RQ5]

    // port 0: full driver while carrying the bus, open drain otherwise
    always_comb
    begin
        p0_out = 8'h00;
        p0_oe = ~st_q.lat[0]; // [RQ6]
        if (bus_cyc && st_q.ph >= peb_pkg::ADDR_FIRST && st_q.ph <= peb_pkg::ADDR_LAST)
        begin
            p0_out = bus_lo; // [RQ9]
            p0_oe = 8'hff;
        end
        else if (is_data && st_q.dm_write && st_q.ph >= peb_pkg::WR_FIRST)
        begin
            p0_out = st_q.dm_wdata; // [RQ22]
            p0_oe = 8'hff;
        end
        else if (st_q.hold_wr)
        begin
            p0_out = st_q.hold_data; // [RQ22]
            p0_oe = 8'hff;
        end
        else if (bus_cyc && st_q.ph >= peb_pkg::FLOAT_FIRST)
        begin
            p0_oe = 8'h00; // [RQ20] [RQ21]
        end
    end

    // next state
    always_comb
    begin
        st_d = st_q;
        st_d.fetch_ack = 1'b0;
        st_d.xmove_done = 1'b0;
        st_d.prev = eff;
        st_d.rise2 = rise1;
        // pins caught as the address strobe falls
        if (!(st_q.st == peb_pkg::PEB_IDLE) && st_q.ph == peb_pkg::ALE_LAST)
            st_d.snap = {p3_in, p2_in, p1_in, p0_in}; // [RQ4]
        // fetch request taken late so the core can answer the previous ack
        if (is_prog && st_q.ph == peb_pkg::REQ_PH)
        begin
            st_d.used = fetch_req && !(xmove_req && st_q.pair_odd); // [RQ16] [RQ17]
            st_d.cyc_addr = fetch_addr;
            st_d.ext = !internal_code_disable_n || (fetch_addr > peb_pkg::INT_ROM_TOP); // [RQ10] [RQ11]
        end
        // capture and release at cycle end
        if (is_prog && st_q.ph == peb_pkg::PROG_LEN)
        begin
            st_d.fetch_ack = st_q.used; // [RQ17]
            st_d.fetch_data = st_q.ext ? p0_in : rom_data;
        end
        if (is_data && st_q.ph == peb_pkg::DATA_LEN)
        begin
            st_d.xmove_done = 1'b1; // [RQ15]
            if (!st_q.dm_write)
                st_d.xmove_rdata = p0_in; // [RQ21]
            st_d.hold_wr = st_q.dm_write;
            st_d.hold_data = st_q.dm_wdata;
        end
        else if (st_q.ph == peb_pkg::HOLD_LAST)
        begin
            st_d.hold_wr = 1'b0;
        end
        if (bus_cyc && cyc_last)
            st_d.lat[0] = peb_pkg::P0_IDLE; // [RQ18]
        // phase counter and cycle choice
        if (cyc_last)
        begin
            st_d.ph = peb_pkg::PH_FIRST; // [RQ24]
            // a data move waits for an even fetch count; the one just ended blocks reissue
            if (xmove_req && !st_q.pair_odd && !is_data)
            begin
                st_d.st = peb_pkg::PEB_DATA; // [RQ15]
                st_d.pair_odd = 1'b0;
                st_d.dm_write = xmove_write;
                st_d.dm_wide = xmove_wide;
                st_d.dm_addr = xmove_addr;
                st_d.dm_wdata = xmove_wdata;
            end
            else
            begin
                st_d.st = peb_pkg::PEB_PROG; // [RQ14] [RQ17]
                st_d.pair_odd = !st_q.pair_odd; // [RQ16]
                st_d.used = 1'b0;
            end
        end
        else
        begin
            st_d.ph = st_q.ph + 4'h1;
        end
        // software write wins over the idle ones load
        if (pwr_en)
            st_d.lat[pwr_sel] = pwr_data;
        // port read result
        if (prd_rmw)
            st_d.prd_data = st_q.lat[prd_sel]; // [RQ2]
        else
            st_d.prd_data = st_q.lat[prd_sel] & st_q.snap[prd_sel]; // [RQ1]
    end

    // state register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
            st_q.lat <= {4{peb_pkg::LATCH_RST}};
            st_q.prev <= {3{peb_pkg::LATCH_RST}};
            st_q.ph <= peb_pkg::PH_FIRST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign fetch_ack = st_q.fetch_ack;
    assign fetch_data = st_q.fetch_data;
    assign rom_addr = st_q.cyc_addr;
    assign xmove_done = st_q.xmove_done;
    assign xmove_rdata = st_q.xmove_rdata;
    assign prd_data = st_q.prd_data;

    // checks
    a_ale_spacing: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ14]
        $rose(ale) |-> ##1 ale ##1 !ale [*4])
        else $error("address strobe spacing wrong");
    a_code_strobe_len: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ20]
        $fell(code_read_strobe_n) |-> st_q.ph == peb_pkg::CRS_FIRST ##1 !code_read_strobe_n
        ##1 code_read_strobe_n)
        else $error("code strobe not two periods");
    a_read_strobe_len: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ21]
        (is_data && !st_q.dm_write && st_q.ph == peb_pkg::RD_FIRST && st_q.lat[3][7]) |->
        (!p3_out[7]) [*6] ##1 p3_out[7])
        else $error("read strobe not T7 to T12");
    a_store_strobe_len: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ22]
        (is_data && st_q.dm_write && st_q.ph == peb_pkg::WR_FIRST && st_q.lat[3][6]) |->
        (!p3_out[6] && p0_out == st_q.dm_wdata) [*7] ##1 (p3_out[6] && p0_oe == 8'hff) ##1 (p0_oe == 8'hff))
        else $error("store strobe or write hold wrong");
    a_p0_ones_end: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ18]
        (bus_cyc && cyc_last && !pwr_en) |=> st_q.lat[0] == peb_pkg::P0_IDLE)
        else $error("port 0 latch not ones after bus cycle");
    a_short_p2_kept: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ12]
        (is_data && !st_q.dm_wide) |-> p2_out == st_q.lat[2])
        else $error("short pointer move changed port 2");
    a_wide_p2_addr: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ13]
        (is_data && st_q.dm_wide && st_q.ph == peb_pkg::DATA_LEN) |-> p2_out == st_q.dm_addr[15:8]
        ##1 p2_out == st_q.lat[2])
        else $error("wide pointer port 2 not driven or not restored");
    a_boost_two: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ5]
        ($rose(st_q.lat[1][0]) ##1 st_q.lat[1][0] ##1 st_q.lat[1][0]) |->
        $past(p1_oe[0], 2) && $past(p1_oe[0]) && !p1_oe[0])
        else $error("port 1 boost not two periods");
    a_rmw_latch: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ2]
        ($past(prd_rmw) && $past(prd_sel) == 2'h1) |-> prd_data == $past(st_q.lat[1]))
        else $error("modify read did not return latch");
    a_plain_and: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ1]
        (!$past(prd_rmw) && $past(prd_sel) == 2'h1) |-> prd_data == ($past(st_q.lat[1]) & $past(st_q.snap[1])))
        else $error("plain read not latch and pin");
    a_data_twelve: assert property (@(posedge mclk) disable iff (!rst_n) // [RQ15]
        (is_data && st_q.ph == peb_pkg::PH_FIRST) |-> ##11 xmove_done == 1'b0 ##1 xmove_done)
        else $error("data cycle not twelve periods");

endmodule : peb_port_bus

// ===== test/peb_ext_mem.sv
`timescale 1ns/1ns
module peb_ext_mem
(
    input wire logic mclk,
    input wire logic ale,
    input wire logic code_read_strobe_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] p0_out,
    input wire logic [7:0] p0_oe,
    input wire logic [7:0] p2_lvl,
    output logic [7:0] p0_lvl,
    output logic [7:0] lo_q,
    output logic [15:0] wa_q,
    output logic [7:0] wd_q
);
    logic ale_q = 1'b0;
    logic [7:0] last_q = 8'h00;
    logic [7:0] rdata;
    logic drive;
    // contents follow address bits 11:8 and 3:0, so a wrong address in those bits gives wrong data
    assign rdata = {lo_q[3:0], p2_lvl[3:0]} ^ 8'ha5;
    assign drive = !code_read_strobe_n || !rd_n;
    // a floating bus shows the inverse of its last level, never a kept value
    assign p0_lvl = (p0_oe & p0_out) | (~p0_oe & (drive ? rdata : ~last_q));
    // demultiplexing latch and write capture
    always @(posedge mclk)
    begin
        last_q <= p0_lvl;
        ale_q <= ale;
        if (ale_q && !ale)
            lo_q <= p0_lvl;
        if (!wr_n)
        begin
            wa_q <= {p2_lvl, lo_q};
            wd_q <= p0_lvl;
        end
    end
endmodule : peb_ext_mem

// ===== test/peb_port_bus_tb.sv
`timescale 1ns/1ns
module peb_port_bus_tb;
    logic mclk = 1'b0, arst_n = 1'b0, icd_n = 1'b1, fetch_req = 1'b0, xmove_req = 1'b0;
    logic xmove_write = 1'b0, xmove_wide = 1'b0, pwr_en = 1'b0, prd_rmw = 1'b0;
    logic [15:0] fetch_addr = 16'h0000, xmove_addr = 16'h0000;
    logic [7:0] rom_data = 8'h00, xmove_wdata = 8'h00, pwr_data = 8'h00, p1_ext = 8'hff;
    logic [1:0] pwr_sel = 2'h0, prd_sel = 2'h0;
    logic [5:0] alt_sel = 6'h00, alt_out = 6'h00;
    logic fetch_ack, xmove_done, ale, crs_n;
    logic [15:0] rom_addr, mem_wa;
    logic [7:0] fetch_data, xmove_rdata, prd_data, mem_lo, mem_wd;
    logic [7:0] p0_in, p0_out, p0_oe, p1_in, p1_out, p1_oe, p2_in, p2_out, p2_oe, p3_in, p3_out, p3_oe;
    integer miscompares = 0;
    integer checked = 0;
    integer cycles = 0;
    // quasi-bidirectional pins: pull-up unless driven, external source can only pull low
    assign p1_in = p1_ext & ((p1_oe & p1_out) | ~p1_oe);
    assign p2_in = (p2_oe & p2_out) | ~p2_oe;
    assign p3_in = (p3_oe & p3_out) | ~p3_oe;
    peb_port_bus u_dut (.mclk(mclk), .arst_n(arst_n), .internal_code_disable_n(icd_n),
        .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_ack(fetch_ack), .fetch_data(fetch_data),
        .rom_addr(rom_addr), .rom_data(rom_data), .xmove_req(xmove_req), .xmove_write(xmove_write),
        .xmove_wide(xmove_wide), .xmove_addr(xmove_addr), .xmove_wdata(xmove_wdata),
        .xmove_done(xmove_done), .xmove_rdata(xmove_rdata), .pwr_en(pwr_en), .pwr_sel(pwr_sel),
        .pwr_data(pwr_data), .prd_sel(prd_sel), .prd_rmw(prd_rmw), .prd_data(prd_data),
        .alt_sel(alt_sel), .alt_out(alt_out), .ale(ale), .code_read_strobe_n(crs_n),
        .p0_in(p0_in), .p0_out(p0_out), .p0_oe(p0_oe), .p1_in(p1_in), .p1_out(p1_out), .p1_oe(p1_oe),
        .p2_in(p2_in), .p2_out(p2_out), .p2_oe(p2_oe), .p3_in(p3_in), .p3_out(p3_out), .p3_oe(p3_oe));
    peb_ext_mem u_mem (.mclk(mclk), .ale(ale), .code_read_strobe_n(crs_n), .rd_n(p3_in[7]),
        .wr_n(p3_in[6]), .p0_out(p0_out), .p0_oe(p0_oe), .p2_lvl(p2_in), .p0_lvl(p0_in),
        .lo_q(mem_lo), .wa_q(mem_wa), .wd_q(mem_wd));
    always #2 mclk = ~mclk;
    // internal program memory answers a cycle after the address moves
    always @(posedge mclk)
        rom_data <= rom_addr[7:0] ^ 8'h3c;
    // hang guard, well beyond the few hundred cycles the tests need
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            conclude();
        end
    end
    function automatic logic [7:0] memf(input logic [15:0] a);
        return {a[3:0], a[11:8]} ^ 8'ha5;
    endfunction : memf
    task automatic conclude();
        $display("compared %0d, mismatched %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic pwr(input logic [1:0] sel, input logic [7:0] d);
        @(posedge mclk);
        pwr_en <= 1'b1;
        pwr_sel <= sel;
        pwr_data <= d;
        @(posedge mclk);
        pwr_en <= 1'b0;
    endtask : pwr
    task automatic prd(input logic rmw, input logic [7:0] exp);
        @(posedge mclk);
        prd_sel <= 2'h1;
        prd_rmw <= rmw;
        @(posedge mclk);
        @(negedge mclk);
        check("port read", exp, prd_data);
    endtask : prd
    // strobe count restarts at each address strobe, so only the answered cycle counts
    task automatic fetch(input logic [15:0] a, input logic ext, input logic [7:0] exp);
        integer n;
        n = 0;
        @(posedge mclk);
        fetch_req <= 1'b1;
        fetch_addr <= a;
        repeat (30)
        begin
            @(negedge mclk);
            n = (ale === 1'b1) ? 0 : n + (crs_n === 1'b0);
            if (fetch_ack === 1'b1)
                break;
        end
        check("fetch data", exp, fetch_data);
        check("code strobe cycles", ext ? 2 : 0, n);
        if (ext)
            check("latched low address", a[7:0], mem_lo);
        @(posedge mclk);
        fetch_req <= 1'b0;
        fetch_addr <= 16'h0000;
    endtask : fetch
    task automatic xmove(input logic wr, input logic wide, input logic [15:0] a, input logic [7:0] d);
        integer n;
        n = 0;
        @(posedge mclk);
        xmove_req <= 1'b1;
        xmove_write <= wr;
        xmove_wide <= wide;
        xmove_addr <= a;
        xmove_wdata <= d;
        repeat (40)
        begin
            @(negedge mclk);
            n = n + ((wr ? p3_in[6] : p3_in[7]) === 1'b0);
            if (xmove_done === 1'b1)
                break;
        end
        check("data strobe cycles", wr ? 7 : 6, n);
        check("port 2 after move", 8'h12, p2_in);
        @(posedge mclk);
        xmove_req <= 1'b0;
    endtask : xmove
    task automatic t_ale();
        integer hi, lo;
        hi = 0;
        lo = 0;
        repeat (60)
        begin
            @(negedge mclk);
            hi = hi + (ale === 1'b1);
            lo = lo + (crs_n === 1'b0);
        end
        check("ale high cycles", 20, hi);
        check("internal code strobes", 0, lo);
        $display("test ale done");
    endtask : t_ale
    task automatic t_fetch();
        @(posedge mclk);
        icd_n <= 1'b0;
        fetch(16'h0042, 1'b1, memf(16'h0042));
        @(posedge mclk);
        icd_n <= 1'b1;
        fetch(16'h0fff, 1'b0, 8'hff ^ 8'h3c);
        fetch(16'h1000, 1'b1, memf(16'h1000));
        fetch(16'h1234, 1'b1, memf(16'h1234));
        $display("test fetch done");
    endtask : t_fetch
    task automatic t_port();
        pwr(2'h1, 8'hf0);
        @(posedge mclk);
        p1_ext <= 8'h3c;
        repeat (14) @(posedge mclk);
        prd(1'b0, 8'h30);
        prd(1'b1, 8'hf0);
        pwr(2'h0, 8'h0f);
        @(negedge mclk);
        check("port 0 drive", 8'hf0, p0_oe);
        pwr(2'h0, 8'hff);
        $display("test port done");
    endtask : t_port
    task automatic t_boost();
        integer n;
        n = 0;
        pwr(2'h1, 8'h00);
        pwr(2'h1, 8'h01);
        repeat (8)
        begin
            @(negedge mclk);
            n = n + (p1_oe[0] === 1'b1);
        end
        check("boost cycles", 2, n);
        check("low bit sinks", 1'b1, p1_oe[1]);
        $display("test boost done");
    endtask : t_boost
    task automatic t_alt();
        @(posedge mclk);
        alt_sel <= 6'h01;
        repeat (2) @(negedge mclk);
        check("alternate low", 1'b0, p3_out[0]);
        @(posedge mclk);
        alt_out <= 6'h01;
        repeat (2) @(negedge mclk);
        check("alternate high", 1'b1, p3_out[0]);
        pwr(2'h3, 8'hfe);
        @(negedge mclk);
        check("latch zero wins", 1'b0, p3_out[0]);
        pwr(2'h3, 8'hff);
        $display("test alt done");
    endtask : t_alt
    task automatic t_move();
        pwr(2'h2, 8'h12);
        // port 0 latch left non-ones so only the end-of-cycle load can make it float
        pwr(2'h0, 8'h55);
        xmove(1'b0, 1'b1, 16'h5678, 8'h00);
        check("read data", memf(16'h5678), xmove_rdata);
        xmove(1'b1, 1'b0, 16'h009a, 8'hc5);
        check("write address", 16'h129a, mem_wa);
        check("write data", 8'hc5, mem_wd);
        repeat (3) @(negedge mclk);
        check("port 0 floats", 8'h00, p0_oe);
        $display("test move done");
    endtask : t_move
    initial
    begin
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        t_ale();
        t_fetch();
        t_port();
        t_boost();
        t_alt();
        t_move();
        conclude();
    end
endmodule : peb_port_bus_tb
